// File: bench/ebw_periph_model.sv
// Behavioural external peripheral answering group-five cycles with an active-low wait line.
`timescale 1ns/1ps
module ebw_periph_model (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic chip_select_five_n,
   input wire logic output_enable_n,
   input wire logic write_n,
   input wire logic data_out_en,
   input wire logic [ebw_pkg::DATA_W-1:0] data_out,
   input wire logic [10:0] ack_dly,
   input wire logic ack_never,
   input wire logic [ebw_pkg::DATA_W-1:0] rd_word,
   output logic ext_data_ack_n,
   output logic [ebw_pkg::DATA_W-1:0] data_in,
   output logic [ebw_pkg::DATA_W-1:0] wr_seen
);
   import ebw_pkg::*;
   logic [10:0] cnt_r;
   logic wr_q_r;
   logic hit;
   assign hit = !chip_select_five_n && !ack_never && (cnt_r >= ack_dly);
   // The model drives the wait line high at the first clock edge that samples the select deasserted.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= 11'h0;
         ext_data_ack_n <= 1'h1;
      end else if (chip_select_five_n) begin
         // Counting from one makes ack_dly the number of clocks after the select asserts.
         cnt_r <= 11'h1;
         ext_data_ack_n <= 1'h1;
      end else begin
         if (cnt_r != 11'h7FF) begin
            cnt_r <= cnt_r + 11'h1;
         end
         ext_data_ack_n <= !hit;
      end
   end
   // Off the bus the data lines toggle every cycle, so a capture at the wrong edge shows.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         data_in <= 16'h0;
      end else begin
         data_in <= (hit && !output_enable_n) ? rd_word : ~data_in;
      end
   end
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wr_q_r <= 1'h1;
         wr_seen <= 16'h0;
      end else begin
         wr_q_r <= write_n;
         if (write_n && !wr_q_r && data_out_en) begin
            wr_seen <= data_out;
         end
      end
   end
endmodule : ebw_periph_model

// File: bench/ebw_wait_cs_tb_top.sv
// Self-checking testbench for the group-five wait/acknowledge cycle engine.
`timescale 1ns/1ps
module ebw_wait_cs_tb_top;
   import ebw_pkg::*;
   logic clk_sys = 1'h0, resetn = 1'h0;
   logic req_valid = 1'h0, req_write = 1'h0, req_dma = 1'h0, ack_src = 1'h0, bec = 1'h0;
   logic [2:0] req_group = 3'h0;
   logic [23:0] req_addr = 24'h0;
   logic [15:0] req_wdata = 16'h0, rd_word = 16'h0, data_in, data_out, rd_data, wr_seen;
   logic [1:0] req_be = 2'h0, be_n;
   logic [5:0] wcnt = 6'h0;
   logic [3:0] rsd = 4'h0, sad = 4'h0, wbd = 4'h0;
   logic [10:0] ack_dly = 11'h0;
   logic ack_never = 1'h0, ack_n, req_ready, cs_n, oe_n, wr_n, dout_en, xfer_done, bus_error;
   logic [23:0] addr_out, addr_cs, addr_wr;
   int cyc = 0, err_total = 0, cmp_count = 0, i, d0, sv;
   int t_take, t_cs_f, t_cs_r, t_oe_f, t_oe_r, t_wr_f, t_wr_r, t_be_f, t_be_r;
   int t_ack, t_done, t_err;
   logic be_seen;
   ebw_wait_cs ebw_wait_cs_inst (.clk_sys(clk_sys), .resetn(resetn), .req_valid(req_valid),
      .req_write(req_write), .req_dma(req_dma), .req_group(req_group), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_be(req_be), .wait_state_count(wcnt),
      .ack_source_select(ack_src), .read_strobe_delay(rsd), .select_assert_delay(sad),
      .write_byte_enable_delay(wbd), .byte_enable_control(bec), .ext_data_ack_n(ack_n),
      .data_in(data_in), .req_ready(req_ready), .addr_out(addr_out), .data_out(data_out),
      .data_out_en(dout_en), .chip_select_five_n(cs_n), .output_enable_n(oe_n),
      .write_n(wr_n), .byte_enable_strobes_n(be_n), .rd_data(rd_data),
      .xfer_done(xfer_done), .bus_error(bus_error));
   ebw_periph_model ebw_periph_model_inst (.clk_sys(clk_sys), .resetn(resetn),
      .chip_select_five_n(cs_n), .output_enable_n(oe_n), .write_n(wr_n),
      .data_out_en(dout_en), .data_out(data_out), .ack_dly(ack_dly), .ack_never(ack_never),
      .rd_word(rd_word), .ext_data_ack_n(ack_n), .data_in(data_in), .wr_seen(wr_seen));
   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   // Edges are recorded in the sample taken at each rising edge, before that edge's updates.
   always @(posedge clk_sys) begin
      cyc++;
      if (t_take < 0 && req_valid && req_ready) t_take = cyc;
      if (t_take >= 0) begin
         if (t_cs_f < 0 && !cs_n) begin
            t_cs_f = cyc;
            addr_cs = addr_out;
         end
         if (t_cs_f >= 0 && t_cs_r < 0 && cs_n) t_cs_r = cyc;
         if (t_oe_f < 0 && !oe_n) t_oe_f = cyc;
         if (t_oe_f >= 0 && t_oe_r < 0 && oe_n) t_oe_r = cyc;
         if (t_wr_f < 0 && !wr_n) begin
            t_wr_f = cyc;
            addr_wr = addr_out;
         end
         if (t_wr_f >= 0 && t_wr_r < 0 && wr_n) t_wr_r = cyc;
         if (t_be_f < 0 && be_n !== 2'h3) t_be_f = cyc;
         if (t_be_f >= 0 && t_be_r < 0 && be_n === 2'h3) t_be_r = cyc;
         if (be_n !== 2'h3) be_seen = 1'h1;
         if (t_ack < 0 && t_cs_f >= 0 && !ack_n) t_ack = cyc;
         if (t_done < 0 && xfer_done) t_done = cyc;
         if (t_err < 0 && bus_error) t_err = cyc;
      end
      if (cyc > 8000) begin
         err_total++;
         print_verdict();
      end
   end
   task automatic run(input logic wr, input logic dma, input logic [2:0] grp,
                      input logic [23:0] addr, input logic [15:0] wd);
      int n;
      n = 0;
      @(negedge clk_sys);
      while (req_ready !== 1'h1 && n < 100) begin
         @(negedge clk_sys);
         n++;
      end
      {t_take, t_cs_f, t_cs_r, t_oe_f, t_oe_r, t_wr_f, t_wr_r} = {7{-32'sd1}};
      {t_be_f, t_be_r, t_ack, t_done, t_err} = {5{-32'sd1}};
      be_seen = 1'h0;
      {req_write, req_dma, req_group, req_addr, req_wdata, req_be} = {wr, dma, grp, addr, wd, 2'h2};
      req_valid = 1'h1;
      @(negedge clk_sys);
      req_valid = 1'h0;
      n = 0;
      while (t_done < 0 && t_err < 0 && n < 1500) begin
         @(negedge clk_sys);
         n++;
      end
      repeat (4) @(negedge clk_sys);
   endtask : run
   initial begin
      repeat (8) @(negedge clk_sys);
      resetn = 1'h1;
      {wcnt, ack_src, ack_dly, rd_word} = {WAIT_COUNT_EXT, 1'h1, 11'd4, 16'hA5C3};
      for (i = 0; i < 2; i++) begin
         {rsd, bec} = {4'(2 * i), 1'(i)};
         run(1'h0, 1'h0, GROUP_FIVE, 24'h00C0DE + 24'(i), 16'h0);
         check(t_cs_f - t_take, 1);
         check(addr_cs, 24'h00C0DE + 24'(i));
         check(t_oe_f - t_take, 1 + 2 * i);
         check(t_oe_r - t_ack >= RD_OE_NEG_MIN_CYC && t_oe_r - t_ack <= RD_OE_NEG_MAX_CYC, 1);
         check(t_cs_r - t_oe_r, RD_CS_NEG_CYC);
         check(rd_data, 16'hA5C3);
         check(be_seen, !i);
         check({t_err < 0, t_done > 0}, 2'h3);
      end
      {ack_dly, bec} = {11'd6, 1'h0};
      for (i = 0; i < 2; i++) begin
         {sad, wbd} = {4'(2 * i), 4'(3 * i)};
         run(1'h1, 1'h0, GROUP_FIVE, 24'h5A5A00 + 24'(i), 16'h3C96 + 16'(i));
         check(t_wr_f - t_take, 1);
         check(addr_wr, 24'h5A5A00 + 24'(i));
         check(t_cs_f - t_wr_f, 2 * i);
         check(t_be_f - t_wr_f, 3 * i);
         check(t_wr_r - t_ack >= WR_RW_NEG_MIN_CYC && t_wr_r - t_ack <= WR_RW_NEG_MAX_CYC, 1);
         check(t_cs_r - t_wr_r, WR_CS_NEG_CYC);
         check(t_be_r - t_cs_r, WR_BE_NEG_CYC);
         check(wr_seen, 16'h3C96 + 16'(i));
      end
      {sad, wbd} = {4'h0, 4'h0};
      run(1'h1, 1'h1, GROUP_FIVE, 24'h000100, 16'h1111);
      sv = t_cs_r;
      run(1'h1, 1'h1, GROUP_FIVE, 24'h000102, 16'h2222);
      check(t_cs_f - sv >= CS_GAP_CYC, 1);
      check(wr_seen, 16'h2222);
      // Outside the external handshake the cycle length must not depend on the wait line.
      ack_dly = 11'd0;
      run(1'h0, 1'h0, 3'h3, 24'h000200, 16'h0);
      d0 = t_done - t_take;
      ack_dly = 11'd30;
      run(1'h0, 1'h0, 3'h3, 24'h000200, 16'h0);
      check(t_done - t_take, d0);
      check(t_err < 0, 1);
      {ack_src, wcnt, ack_never} = {1'h0, 6'h04, 1'h1};
      run(1'h0, 1'h0, GROUP_FIVE, 24'h000300, 16'h0);
      d0 = t_done - t_take;
      check({t_err < 0, t_done > 0}, 2'h3);
      {ack_never, ack_dly} = {1'h0, 11'd0};
      run(1'h0, 1'h0, GROUP_FIVE, 24'h000300, 16'h0);
      check(t_done - t_take, d0);
      {ack_src, wcnt, ack_never} = {1'h1, WAIT_COUNT_EXT, 1'h1};
      run(1'h0, 1'h0, GROUP_FIVE, 24'h000400, 16'h0);
      // The wait count starts with the select, not with the delayed read strobe.
      check(t_err - t_cs_f >= TIMEOUT_COUNTS && t_err - t_cs_f <= TIMEOUT_COUNTS + 1, 1);
      check(t_oe_r, t_err);
      check(t_done < 0, 1);
      {ack_never, ack_dly, rd_word} = {1'h0, 11'd1019, 16'h7E81};
      run(1'h0, 1'h0, GROUP_FIVE, 24'h000500, 16'h0);
      check({t_err < 0, t_done > 0}, 2'h3);
      check(rd_data, 16'h7E81);
      print_verdict();
   end
endmodule : ebw_wait_cs_tb_top

// File: core/ebw_timeout.sv
// Bus time-out monitor for cycles waiting on the external acknowledge.
`timescale 1ns/1ps
module ebw_timeout (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic run,
   output logic expired
);
   import ebw_pkg::*;
   logic [CNT_W-1:0] cnt_r;

   // The count restarts whenever the cycle leaves the waiting phase.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= '0;
      end else if (run) begin
         cnt_r <= cnt_r + CNT_W'(1);
      end else begin
         cnt_r <= '0;
      end
   end

   assign expired = run && (cnt_r == CNT_W'(TIMEOUT_COUNTS - 1)); // R1
endmodule : ebw_timeout

// File: core/ebw_wait_cs.sv
// Chip-select group five cycle engine with external wait acknowledge.
`timescale 1ns/1ps
module ebw_wait_cs (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_dma,
   input wire logic [ebw_pkg::GRP_W-1:0] req_group,
   input wire logic [ebw_pkg::ADDR_W-1:0] req_addr,
   input wire logic [ebw_pkg::DATA_W-1:0] req_wdata,
   input wire logic [ebw_pkg::BE_W-1:0] req_be,
   input wire logic [ebw_pkg::WAIT_CNT_W-1:0] wait_state_count,
   input wire logic ack_source_select,
   input wire logic [ebw_pkg::DLY_W-1:0] read_strobe_delay,
   input wire logic [ebw_pkg::DLY_W-1:0] select_assert_delay,
   input wire logic [ebw_pkg::DLY_W-1:0] write_byte_enable_delay,
   input wire logic byte_enable_control,
   input wire logic ext_data_ack_n,
   input wire logic [ebw_pkg::DATA_W-1:0] data_in,
   output logic req_ready,
   output logic [ebw_pkg::ADDR_W-1:0] addr_out,
   output logic [ebw_pkg::DATA_W-1:0] data_out,
   output logic data_out_en,
   output logic chip_select_five_n,
   output logic output_enable_n,
   output logic write_n,
   output logic [ebw_pkg::BE_W-1:0] byte_enable_strobes_n,
   output logic [ebw_pkg::DATA_W-1:0] rd_data,
   output logic xfer_done,
   output logic bus_error
);
   import ebw_pkg::*;

   ebw_state_t state_r;
   logic ack_s1_r;
   logic ack_s2_r;
   logic [CNT_W-1:0] el_r;
   logic [CNT_W-1:0] el_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic write_r;
   logic dma_r;
   logic ext_mode_r;
   logic be_ctl_r;
   logic [WAIT_CNT_W-1:0] wstate_r;
   logic [DLY_W-1:0] rd_dly_r;
   logic [DLY_W-1:0] sel_dly_r;
   logic [DLY_W-1:0] wbe_dly_r;
   logic [BE_W-1:0] be_r;
   logic take;
   logic ack_seen;
   logic expired;
   logic abort;
   logic cs_neg_now;
   logic be_end_now;

   assign take = req_valid && (state_r == ST_IDLE);
   assign el_nxt = el_r + CNT_W'(1);
   // Internal wait states end the cycle on the count alone, the pin is ignored.
   assign ack_seen = (state_r == ST_ACC) &&
                     (ext_mode_r ? !ack_s2_r : (el_r >= CNT_W'(wstate_r))); // R4
   assign abort = expired && !ack_seen;
   assign cs_neg_now = (state_r == ST_STRB) &&
                       (cnt_r == (write_r ? CNT_W'(WR_CS_NEG_CYC) : CNT_W'(RD_CS_NEG_CYC)));
   assign be_end_now = (state_r == ST_BEND) && (cnt_r == CNT_W'(WR_BE_NEG_CYC));

   ebw_timeout ebw_timeout_inst (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .run((state_r == ST_ACC) && ext_mode_r),
      .expired(expired)
   );

   // Two stages cost two clocks of acknowledge latency but keep an
   // asynchronous peripheral from making the state machine metastable.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ack_s1_r <= STROBE_IDLE_N;
         ack_s2_r <= STROBE_IDLE_N;
      end else begin
         ack_s1_r <= ext_data_ack_n; // R19
         ack_s2_r <= ack_s1_r; // R19
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_IDLE;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (take) begin
                  state_r <= ST_ACC;
               end
            end
            ST_ACC: begin
               if (ack_seen) begin
                  state_r <= ST_STRB;
               end else if (abort) begin
                  state_r <= ST_GAP; // R1
               end
            end
            ST_STRB: begin
               if (cs_neg_now) begin
                  state_r <= (write_r && !dma_r) ? ST_BEND : ST_GAP;
               end
            end
            ST_BEND: begin
               if (be_end_now) begin
                  state_r <= ST_GAP;
               end
            end
            ST_GAP: begin
               state_r <= ST_IDLE; // R18
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         el_r <= '0;
         cnt_r <= '0;
      end else begin
         if (take) begin
            el_r <= '0;
         end else if (state_r == ST_ACC) begin
            el_r <= el_nxt;
         end
         if ((state_r == ST_ACC && ack_seen) || cs_neg_now) begin
            cnt_r <= CNT_W'(1);
         end else if (state_r == ST_STRB || state_r == ST_BEND) begin
            cnt_r <= cnt_r + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         write_r <= 1'b0;
         dma_r <= 1'b0;
         ext_mode_r <= 1'b0;
         be_ctl_r <= 1'b0;
         wstate_r <= '0;
         rd_dly_r <= '0;
         sel_dly_r <= '0;
         wbe_dly_r <= '0;
         be_r <= '0;
      end else if (take) begin
         write_r <= req_write;
         dma_r <= req_dma;
         ext_mode_r <= (req_group == GROUP_FIVE) && (wait_state_count == WAIT_COUNT_EXT) &&
                       ack_source_select; // R2 R3
         be_ctl_r <= byte_enable_control;
         wstate_r <= wait_state_count;
         rd_dly_r <= read_strobe_delay;
         sel_dly_r <= select_assert_delay;
         wbe_dly_r <= write_byte_enable_delay;
         be_r <= req_be;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         chip_select_five_n <= STROBE_IDLE_N;
      end else if (take) begin
         // Reads drive the select at once; writes wait for the programmed delay.
         chip_select_five_n <= req_write && (select_assert_delay != '0); // R9 R16
      end else if (state_r == ST_ACC) begin
         if (abort) begin
            chip_select_five_n <= STROBE_IDLE_N;
         end else if (write_r && el_nxt >= CNT_W'(sel_dly_r)) begin
            chip_select_five_n <= 1'b0; // R16
         end
      end else if (cs_neg_now) begin
         chip_select_five_n <= STROBE_IDLE_N; // R8 R13
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         output_enable_n <= STROBE_IDLE_N;
         write_n <= STROBE_IDLE_N;
      end else if (take) begin
         output_enable_n <= req_write || (read_strobe_delay != '0); // R10
         write_n <= !req_write; // R15
      end else if (state_r == ST_ACC) begin
         if (ack_seen || abort) begin
            output_enable_n <= STROBE_IDLE_N; // R6
            write_n <= STROBE_IDLE_N; // R12
         end else if (!write_r && el_nxt >= CNT_W'(rd_dly_r)) begin
            output_enable_n <= 1'b0; // R10
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         byte_enable_strobes_n <= BE_IDLE_N;
      end else if (take) begin
         if (req_write) begin
            byte_enable_strobes_n <= (write_byte_enable_delay == '0) ? ~req_be : BE_IDLE_N; // R17
         end else begin
            byte_enable_strobes_n <= (read_strobe_delay == '0 && !byte_enable_control) ?
                                     ~req_be : BE_IDLE_N; // R10 R11
         end
      end else if (state_r == ST_ACC) begin
         if (abort || (!write_r && ack_seen)) begin
            byte_enable_strobes_n <= BE_IDLE_N;
         end else if (write_r && el_nxt >= CNT_W'(wbe_dly_r)) begin
            byte_enable_strobes_n <= ~be_r; // R17
         end else if (!write_r && !be_ctl_r && el_nxt >= CNT_W'(rd_dly_r)) begin
            byte_enable_strobes_n <= ~be_r; // R10 R11
         end
      end else if ((cs_neg_now && dma_r) || be_end_now) begin
         byte_enable_strobes_n <= BE_IDLE_N; // R14
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         addr_out <= '0;
         data_out <= '0;
         data_out_en <= 1'b0;
      end else if (take) begin
         addr_out <= req_addr; // R9 R15
         data_out <= req_wdata;
         data_out_en <= req_write;
      end else if (abort || cs_neg_now) begin
         // Write data is held past the strobe to cover the peripheral's hold need.
         data_out_en <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rd_data <= '0;
      end else if (ack_seen && !write_r) begin
         rd_data <= data_in; // R7
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         xfer_done <= 1'b0;
         bus_error <= 1'b0;
         req_ready <= 1'b1;
      end else begin
         xfer_done <= (cs_neg_now && !(write_r && !dma_r)) || be_end_now;
         bus_error <= (state_r == ST_ACC) && abort; // R1
         if (take) begin
            req_ready <= 1'b0;
         end else if (state_r == ST_GAP) begin
            req_ready <= 1'b1;
         end
      end
   end

   localparam int A_RD_LO = RD_OE_NEG_MIN_CYC;
   localparam int A_RD_HI = RD_OE_NEG_MAX_CYC;
   localparam int A_WR_LO = WR_RW_NEG_MIN_CYC;
   localparam int A_WR_HI = WR_RW_NEG_MAX_CYC;
   localparam int A_RD_CS = RD_CS_NEG_CYC;
   localparam int A_WR_CS = WR_CS_NEG_CYC;
   localparam int A_WR_BE = WR_BE_NEG_CYC;

   default clocking cb_sys @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   property p_timeout;
      $rose(bus_error) |-> $past(el_r) == CNT_W'(TIMEOUT_COUNTS - 1) && $past(ext_mode_r);
   endproperty
   a_timeout: assert property (p_timeout) else $error("bus error not at timeout count"); // R1

   property p_group_only;
      take && req_group != GROUP_FIVE |=> !ext_mode_r;
   endproperty
   a_group_only: assert property (p_group_only) else $error("ack honoured by other group"); // R2

   property p_ext_mode;
      take && req_group == GROUP_FIVE && wait_state_count == WAIT_COUNT_EXT &&
      ack_source_select |=> ext_mode_r;
   endproperty
   a_ext_mode: assert property (p_ext_mode) else $error("external handshake not chosen"); // R3

   property p_internal_end;
      state_r == ST_ACC && !ext_mode_r && el_r == CNT_W'(wstate_r) |=> state_r == ST_STRB;
   endproperty
   a_internal_end: assert property (p_internal_end) else $error("internal wait not ended"); // R4

   sequence s_ack_fall;
      state_r == ST_ACC && ext_mode_r && !ext_data_ack_n && $past(ext_data_ack_n) &&
      ack_s2_r && !expired;
   endsequence

   property p_rd_oe_neg;
      s_ack_fall ##0 !write_r |-> ##[A_RD_LO:A_RD_HI] $rose(output_enable_n);
   endproperty
   a_rd_oe_neg: assert property (p_rd_oe_neg) else $error("read strobe negation late"); // R6

   property p_wr_neg;
      s_ack_fall ##0 write_r |-> ##[A_WR_LO:A_WR_HI] $rose(write_n);
   endproperty
   a_wr_neg: assert property (p_wr_neg) else $error("write strobe negation late"); // R12

   property p_rd_cs_neg;
      $rose(output_enable_n) && !write_r && !bus_error |-> ##[A_RD_CS:A_RD_CS]
         $rose(chip_select_five_n);
   endproperty
   a_rd_cs_neg: assert property (p_rd_cs_neg) else $error("read select negation off"); // R8

   property p_wr_cs_neg;
      $rose(write_n) && !bus_error |-> ##[A_WR_CS:A_WR_CS] $rose(chip_select_five_n);
   endproperty
   a_wr_cs_neg: assert property (p_wr_cs_neg) else $error("write select negation off"); // R13

   property p_wr_be_neg;
      $rose(chip_select_five_n) && write_r && !dma_r && !bus_error |->
         ##[A_WR_BE:A_WR_BE] byte_enable_strobes_n == BE_IDLE_N;
   endproperty
   a_wr_be_neg: assert property (p_wr_be_neg) else $error("write byte enables not negated"); // R14

   property p_rd_start;
      take && !req_write |=> !chip_select_five_n && addr_out == $past(req_addr);
   endproperty
   a_rd_start: assert property (p_rd_start) else $error("read start wrong"); // R9

   property p_wr_start;
      take && req_write |=> !write_n && addr_out == $past(req_addr);
   endproperty
   a_wr_start: assert property (p_wr_start) else $error("write start wrong"); // R15

   property p_rd_be_ctl;
      state_r == ST_ACC && !write_r && be_ctl_r |-> byte_enable_strobes_n == BE_IDLE_N;
   endproperty
   a_rd_be_ctl: assert property (p_rd_be_ctl) else $error("read byte enables driven"); // R11

   property p_gap;
      $rose(chip_select_five_n) |=> chip_select_five_n;
   endproperty
   a_gap: assert property (p_gap) else $error("select gap too short"); // R18

   c_read: cover property ($rose(output_enable_n) && !write_r && !bus_error);
   c_write: cover property ($rose(write_n) && !bus_error);
   c_timeout: cover property ($rose(bus_error));
   c_dma_b2b: cover property (xfer_done && dma_r ##[1:4] take);
endmodule : ebw_wait_cs

// File: shared/ebw_pkg.sv
// Constants, field widths and state type shared by the group-five wait/acknowledge port.
// Contract
// R1: Bus error after 1022 unacknowledged counts.
// R2: External acknowledge honoured by group five only.
// R3: Handshake needs all-ones wait count, external source.
// R4: Internal wait states time the cycle themselves.
// R5: Peripheral drops wait within 1019 clocks.
// R6: Read strobe negates 2..3 clocks after wait.
// R7: Peripheral read data valid one clock after wait.
// R8: Read select negates 1.5 clocks after strobe.
// R9: Read start drives address and select together.
// R10: Read strobe delay sets output and byte enables.
// R11: Read byte enables only with control bit clear.
// R12: Write strobe negates 1..2 clocks after wait.
// R13: Write strobe negates 2.5 clocks before select.
// R14: Non-DMA write byte enables negate after select.
// R15: Write start drives address and write strobe.
// R16: Select assert delay sets select assertion.
// R17: Write byte-enable delay sets byte enable assertion.
// R18: Select stays high one clock between cycles.
// R19: Wait input is synchronised before use.
package ebw_pkg;
   localparam int T_CLK_PS = 5000;
   localparam int TIMEOUT_COUNTS = 1022;
   localparam int RD_OE_NEG_MIN_PS = 2 * T_CLK_PS + 2200;
   localparam int RD_OE_NEG_MAX_PS = 3 * T_CLK_PS + 7170;
   localparam int WR_RW_NEG_MIN_PS = 1 * T_CLK_PS + 2150;
   localparam int WR_RW_NEG_MAX_PS = 2 * T_CLK_PS + 7340;
   localparam int RD_CS_NEG_PS = (3 * T_CLK_PS) / 2 + 240;
   localparam int WR_CS_NEG_PS = (5 * T_CLK_PS) / 2 - 290;
   localparam int WR_BE_NEG_PS = (3 * T_CLK_PS) / 2 + 740;
   localparam int CS_GAP_PS = T_CLK_PS;
   localparam int RD_OE_NEG_MIN_CYC = (RD_OE_NEG_MIN_PS + T_CLK_PS - 1) / T_CLK_PS;
   localparam int RD_OE_NEG_MAX_CYC = RD_OE_NEG_MAX_PS / T_CLK_PS;
   localparam int WR_RW_NEG_MIN_CYC = (WR_RW_NEG_MIN_PS + T_CLK_PS - 1) / T_CLK_PS;
   localparam int WR_RW_NEG_MAX_CYC = WR_RW_NEG_MAX_PS / T_CLK_PS;
   localparam int RD_CS_NEG_CYC = (RD_CS_NEG_PS + T_CLK_PS - 1) / T_CLK_PS;
   localparam int WR_CS_NEG_CYC = (WR_CS_NEG_PS + T_CLK_PS - 1) / T_CLK_PS;
   localparam int WR_BE_NEG_CYC = (WR_BE_NEG_PS + T_CLK_PS - 1) / T_CLK_PS;
   localparam int CS_GAP_CYC = (CS_GAP_PS + T_CLK_PS - 1) / T_CLK_PS;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int BE_W = 2;
   localparam int WAIT_CNT_W = 6;
   localparam int DLY_W = 4;
   localparam int GRP_W = 3;
   localparam int CNT_W = 11;
   localparam logic [WAIT_CNT_W-1:0] WAIT_COUNT_EXT = 6'h3F;
   localparam logic [GRP_W-1:0] GROUP_FIVE = 3'h5;
   localparam logic [BE_W-1:0] BE_IDLE_N = 2'h3;
   localparam logic STROBE_IDLE_N = 1'h1;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ACC = 3'b001,
      ST_STRB = 3'b010,
      ST_BEND = 3'b011,
      ST_GAP = 3'b100
   } ebw_state_t;
endpackage : ebw_pkg
